// ===== common/acrs_pkg.sv
// Purpose: Shared constants and types for the conversion/readout sequencer.
// Assumes: One 20 MHz clock; every time is turned into whole clock cycles here.
// Notes: Least times round up, longest times round down, none below one cycle.
package acrs_pkg;

  // Clock rate and counter width
  localparam int CLK_MHZ = 20;
  localparam int CW = 15;
  typedef logic [CW-1:0] acrs_cnt_t;

  // Least time in ns to cycles, rounded up, at least one
  function automatic int acrs_ceil_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  // Pin timing as specified
  localparam int T_ACQ_NS = 700;
  localparam int T_PH_START_NS = 25;
  localparam int T_PL_START_NS = 25;
  localparam int T_PH_RST_NS = 50;
  localparam int T_SU_RST_START_NS = 25;
  localparam int T_SKEW_MAX_US = 500;
  localparam int T_START_CS_NS = 10;
  localparam int T_CS_BUSY_NS = 40;
  localparam int T_BUSY_CS_NS = 0;
  localparam int T_CS_START_NS = 10;

  // Same times in clock cycles
  localparam acrs_cnt_t ACQ_CYC = acrs_cnt_t'(acrs_ceil_cyc(T_ACQ_NS));
  localparam acrs_cnt_t PH_CYC = acrs_cnt_t'(acrs_ceil_cyc(T_PH_START_NS));
  localparam acrs_cnt_t PL_CYC = acrs_cnt_t'(acrs_ceil_cyc(T_PL_START_NS));
  localparam acrs_cnt_t RST_CYC = acrs_cnt_t'(acrs_ceil_cyc(T_PH_RST_NS));
  localparam acrs_cnt_t RSTCN_CYC = acrs_cnt_t'(acrs_ceil_cyc(T_SU_RST_START_NS));
  localparam int SKEW_MAX_CYC = T_SKEW_MAX_US * CLK_MHZ;
  localparam acrs_cnt_t CNCS_CYC = acrs_cnt_t'(acrs_ceil_cyc(T_START_CS_NS));
  localparam acrs_cnt_t CSBSY_CYC = acrs_cnt_t'(acrs_ceil_cyc(T_CS_BUSY_NS));
  localparam acrs_cnt_t BSYCS_CYC = acrs_cnt_t'(acrs_ceil_cyc(T_BUSY_CS_NS));
  localparam acrs_cnt_t CSCN_CYC = acrs_cnt_t'(acrs_ceil_cyc(T_CS_START_NS));

  // Readout window and shortest conversion assumed
  localparam acrs_cnt_t READ_CYC = 15'h0010;
  localparam acrs_cnt_t CONV_MIN_CYC = 15'h0014;
  localparam logic DURING_OK = (PH_CYC + READ_CYC + CSBSY_CYC) <= CONV_MIN_CYC;

  // Sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_RST = 7'h01,
    ST_REC = 7'h02,
    ST_IDLE = 7'h04,
    ST_CONV = 7'h08,
    ST_BUSY = 7'h10,
    ST_READ = 7'h20,
    ST_GAP = 7'h40
  } acrs_state_t;

  // Whole state of the sequencer
  typedef struct packed {
    acrs_state_t st;
    acrs_cnt_t cnt;
    acrs_cnt_t skew;
    logic a;
    logic b;
    logic rst;
    logic cs_n;
    logic rd_dur;
    logic seen;
    logic rdy;
    logic done;
    logic bsy1;
    logic bsy2;
    logic bsyp;
  } acrs_reg_t;

  // Whole state of the acquisition timer
  typedef struct packed {
    acrs_cnt_t left;
    logic done;
  } acrs_tmr_t;

endpackage

// ===== hw/acrs_host.sv
// Purpose: Host sequencer for conversion starts, converter reset and readout chip select.
// Assumes: Busy arrives from the pin and is synchronised; the converter never
//   finishes a conversion in fewer than CONV_MIN_CYC clocks.
// Notes: Readout itself (strobes, data) is done elsewhere while cs_n_o is low.
// Functional notes
// - Wait 0.7 us after busy falls
// - Start pulses high at least 25 ns
// - Start inputs low at least 25 ns
// - Reset pulse high at least 50 ns
// - 25 ns from reset release to start
// - Second start within 500 us of first
// - Chip select 10 ns after start edge
// - During-conversion read ends 40 ns before busy falls
// - After-conversion read waits for busy fall
// - Chip select high 10 ns before next start
`timescale 1ns/10ps
module acrs_host #(
  parameter int MAX_SKEW_CYC = acrs_pkg::SKEW_MAX_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // User requests
  input wire logic conv_req_i,
  input wire logic reset_req_i,
  input wire logic read_during_i,
  input wire acrs_pkg::acrs_cnt_t stagger_i,
  // User status
  output logic ready_o,
  output logic done_o,
  output logic busy_o,
  // Converter pins
  input wire logic busy_pin_i,
  output logic start_group_a_o,
  output logic start_group_b_o,
  output logic conv_reset_o,
  output logic cs_n_o
);
  import acrs_pkg::*;

  acrs_reg_t q, d;
  logic acq_done;
  logic busy_fall;
  acrs_cnt_t nxt;
  acrs_cnt_t skew_lim;

  // Busy fall seen after two synchroniser stages
  assign busy_fall = q.bsyp & ~q.bsy2;
  assign nxt = q.cnt + 15'h0001;
  assign skew_lim = (stagger_i > acrs_cnt_t'(MAX_SKEW_CYC)) ?
                    acrs_cnt_t'(MAX_SKEW_CYC) : stagger_i;

  // Acquisition wait starts at every busy fall
  acrs_timer u_acq (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .load_i(busy_fall),
    .value_i(ACQ_CYC),
    .done_o(acq_done)
  );

  // Next state
  always_comb begin
    d = q;
    d.bsy1 = busy_pin_i;
    d.bsy2 = q.bsy1;
    d.bsyp = q.bsy2;
    d.done = 1'b0;
    d.rdy = 1'b0;
    case (q.st)
      ST_RST: begin
        d.rst = 1'b1;
        d.cnt = nxt;
        if (nxt >= RST_CYC) begin
          d.st = ST_REC;
          d.rst = 1'b0;
          d.cnt = 15'h0000;
        end
      end
      ST_REC: begin
        d.cnt = nxt;
        if (nxt >= RSTCN_CYC) begin
          d.st = ST_IDLE;
          d.rdy = acq_done;
        end
      end
      ST_IDLE: begin
        d.rdy = acq_done;
        if (reset_req_i) begin
          d.st = ST_RST;
          d.rst = 1'b1;
          d.rdy = 1'b0;
          d.cnt = 15'h0000;
        end else if (conv_req_i && acq_done) begin
          d.st = ST_CONV;
          d.rdy = 1'b0;
          d.cnt = 15'h0000;
          d.skew = skew_lim;
          d.a = 1'b1;
          d.b = (skew_lim == 15'h0000);
          d.rd_dur = read_during_i & DURING_OK;
        end
      end
      ST_CONV: begin
        // Group a rises first unless the stagger is zero, group b follows after the stagger
        d.cnt = nxt;
        d.a = nxt < PH_CYC;
        d.b = (nxt >= q.skew) && (nxt < q.skew + PH_CYC);
        if (nxt >= q.skew + PH_CYC) begin
          d.st = ST_BUSY;
          d.cnt = 15'h0000;
          d.seen = 1'b0;
          d.cs_n = ~q.rd_dur;
        end
      end
      ST_BUSY: begin
        // Optional readout of earlier results while converting
        d.cnt = nxt;
        d.cs_n = ~(q.rd_dur && (nxt < READ_CYC));
        if (q.bsy2) begin
          d.seen = 1'b1;
        end
        if (busy_fall && q.seen) begin
          d.cnt = 15'h0000;
          d.cs_n = ~(~q.rd_dur);
          d.st = q.rd_dur ? ST_GAP : ST_READ;
        end
      end
      ST_READ: begin
        d.cnt = nxt;
        if (nxt >= READ_CYC) begin
          d.cs_n = 1'b1;
          d.st = ST_GAP;
          d.cnt = 15'h0000;
        end
      end
      ST_GAP: begin
        d.cnt = nxt;
        if (nxt >= CSCN_CYC) begin
          d.st = ST_IDLE;
          d.done = 1'b1;
        end
      end
      default: begin
        d.st = ST_RST;
        d.cnt = 15'h0000;
        d.rst = 1'b1;
        d.a = 1'b0;
        d.b = 1'b0;
        d.cs_n = 1'b1;
      end
    endcase
  end

  // State register; converter held in reset after our own reset
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '{st: ST_RST, cnt: 15'h0000, skew: 15'h0000, a: 1'b0, b: 1'b0,
             rst: 1'b1, cs_n: 1'b1, rd_dur: 1'b0, seen: 1'b0, rdy: 1'b0,
             done: 1'b0, bsy1: 1'b0, bsy2: 1'b0, bsyp: 1'b0};
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign start_group_a_o = q.a;
  assign start_group_b_o = q.b;
  assign conv_reset_o = q.rst;
  assign cs_n_o = q.cs_n;
  assign ready_o = q.rdy;
  assign done_o = q.done;
  assign busy_o = q.bsy2;

  // Checking helpers: cycles since busy fall and since first start edge
  acrs_cnt_t chk_acq_q;
  acrs_cnt_t chk_skew_q;
  logic chk_pend_q;
  acrs_cnt_t chk_ta_q;
  acrs_cnt_t chk_tb_q;
  acrs_cnt_t chk_tr_q;

  // Saturating count of cycles a pin has stood at its level
  function automatic acrs_cnt_t stand_inc(input acrs_cnt_t v);
    return (v == 15'h7fff) ? v : v + 15'h0001;
  endfunction

  // Level age of start and reset pins; long ago at reset
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      chk_ta_q <= 15'h7fff;
      chk_tb_q <= 15'h7fff;
      chk_tr_q <= 15'h7fff;
    end else begin
      chk_ta_q <= (d.a != q.a) ? 15'h0001 : stand_inc(chk_ta_q);
      chk_tb_q <= (d.b != q.b) ? 15'h0001 : stand_inc(chk_tb_q);
      chk_tr_q <= (d.rst != q.rst) ? 15'h0001 : stand_inc(chk_tr_q);
    end
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      chk_acq_q <= 15'h7fff;
      chk_skew_q <= 15'h0000;
      chk_pend_q <= 1'b0;
    end else begin
      chk_acq_q <= busy_fall ? 15'h0001 :
                   (chk_acq_q == 15'h7fff) ? chk_acq_q : chk_acq_q + 15'h0001;
      chk_pend_q <= (q.a & ~q.b & ~chk_pend_q) | (chk_pend_q & ~q.b);
      chk_skew_q <= chk_pend_q ? chk_skew_q + 15'h0001 : 15'h0000;
    end
  end

  sequence s_start_edge;
    $rose(start_group_a_o) || $rose(start_group_b_o);
  endsequence

  sequence s_cs_open;
    $fell(cs_n_o) && !q.rd_dur;
  endsequence

  a_acq_spacing: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_start_edge |-> chk_acq_q >= ACQ_CYC)
    else $error("start edge too soon after busy fall");
  a_start_high: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(start_group_a_o) |-> $past(chk_ta_q) >= PH_CYC)
    else $error("start a pulse too short");
  a_start_b_high: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(start_group_b_o) |-> $past(chk_tb_q) >= PH_CYC)
    else $error("start b pulse too short");
  a_start_low: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(start_group_b_o) |-> $past(chk_tb_q) >= PL_CYC)
    else $error("start b low time too short");
  a_start_a_low: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(start_group_a_o) |-> $past(chk_ta_q) >= PL_CYC)
    else $error("start a low time too short");
  a_reset_width: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(conv_reset_o) |-> $past(chk_tr_q) >= RST_CYC)
    else $error("converter reset pulse too short");
  a_reset_setup: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_start_edge |-> !conv_reset_o && !$past(conv_reset_o, 1))
    else $error("start edge too soon after reset release");
  a_skew_bound: assert property (@(posedge mclk_i) disable iff (rst_i)
    chk_pend_q |-> chk_skew_q < acrs_cnt_t'(MAX_SKEW_CYC))
    else $error("second start edge too late");
  a_cs_after_start: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_start_edge |-> cs_n_o)
    else $error("chip select too close to start edge");
  a_cs_before_fall: assert property (@(posedge mclk_i) disable iff (rst_i)
    busy_fall && q.st == ST_BUSY |-> cs_n_o)
    else $error("chip select still low at busy fall");
  a_read_after: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_cs_open |-> !q.bsy2 && $past(q.st) == ST_BUSY)
    else $error("after-conversion read began before busy fall");
  a_cs_gap: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_start_edge |-> $past(cs_n_o, 1) && $past(cs_n_o, 2))
    else $error("chip select too close to next start");

endmodule

// ===== hw/acrs_timer.sv
// Purpose: Down counter that flags when a loaded wait has run out.
// Assumes: Load and value come from logic on the same clock.
// Notes: Done is high from reset until the first load.
`timescale 1ns/10ps
module acrs_timer (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Load request
  input wire logic load_i,
  input wire acrs_pkg::acrs_cnt_t value_i,
  // Expiry
  output logic done_o
);
  import acrs_pkg::*;

  acrs_tmr_t q, d;

  // Count down, reload wins
  always_comb begin
    d = q;
    if (load_i) begin
      d.left = value_i;
      d.done = 1'b0;
    end else if (q.left > 15'h0001) begin
      d.left = q.left - 15'h0001;
    end else begin
      d.left = 15'h0000;
      d.done = 1'b1;
    end
  end

  // State register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '{left: 15'h0000, done: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign done_o = q.done;

endmodule

// ===== testbench/acrs_dev_model.sv
// Purpose: Behavioural converter that answers starts with busy and times the host's pins.
// Assumes: Conversion lasts conv_ns_i; busy rises 20 ns after the trailing start edge.
// Notes: Each host timing slip adds one to viol_o.
`timescale 1ns/10ps
module acrs_dev_model #(
  parameter real SKEW_NS = 2500.0
) (
  // Converter pins
  input wire logic start_group_a_i,
  input wire logic start_group_b_i,
  input wire logic conv_reset_i,
  input wire logic cs_n_i,
  input wire logic read_during_i,
  input var real conv_ns_i,
  output logic busy_o,
  output logic [31:0] viol_o
);
  // Edge time stamps, long ago at start
  real a_up = -1.0e9, a_dn = -1.0e9, b_up = -1.0e9, b_dn = -1.0e9;
  real r_up = -1.0e9, r_dn = -1.0e9, c_up = -1.0e9, bsy_dn = -1.0e9, trail = -1.0e9;
  logic ga = 1'b0, gb = 1'b0, conv = 1'b0, in_rd = 1'b0;
  event go;
  initial begin
    busy_o = 1'b0;
    viol_o = '0;
  end
  task automatic chk(input bit ok);
    if (!ok) viol_o = viol_o + 1;
  endtask
  // Trailing start begins a conversion
  task automatic start_up(input real first);
    chk($realtime - r_dn >= 25.0);
    chk(cs_n_i === 1'b1 && $realtime - c_up >= 10.0);
    if (ga && gb) begin
      chk($realtime - first <= SKEW_NS);
      chk($realtime - bsy_dn >= 700.0);
      trail = $realtime;
      ga = 1'b0;
      gb = 1'b0;
      conv = 1'b1;
      ->go;
    end
  endtask
  always @(posedge start_group_a_i) begin
    chk($realtime - a_dn >= 25.0);
    a_up = $realtime;
    ga = 1'b1;
    start_up(gb ? b_up : a_up);
  end
  always @(posedge start_group_b_i) begin
    chk($realtime - b_dn >= 25.0);
    b_up = $realtime;
    gb = 1'b1;
    start_up(ga ? a_up : b_up);
  end
  // Pulse widths
  always @(negedge start_group_a_i) begin
    chk($realtime - a_up >= 25.0);
    a_dn = $realtime;
  end
  always @(negedge start_group_b_i) begin
    chk($realtime - b_up >= 25.0);
    b_dn = $realtime;
  end
  always @(posedge conv_reset_i) begin
    r_up = $realtime;
    ga = 1'b0;
    gb = 1'b0;
  end
  always @(negedge conv_reset_i) begin
    chk($realtime - r_up >= 50.0);
    r_dn = $realtime;
  end
  // Chip select windows
  always @(negedge cs_n_i) begin
    if (conv) begin
      chk(read_during_i === 1'b1);
      chk($realtime - trail >= 10.0);
      in_rd = 1'b1;
    end
  end
  always @(posedge cs_n_i) begin
    c_up = $realtime;
  end
  // Busy spans conversion until results are ready
  always begin
    @go;
    #20 busy_o = 1'b1;
    #(conv_ns_i);
    chk(!in_rd || (cs_n_i === 1'b1 && $realtime - c_up >= 40.0));
    busy_o = 1'b0;
    bsy_dn = $realtime;
    conv = 1'b0;
    in_rd = 1'b0;
  end
endmodule

// ===== testbench/acrs_host_bench.sv
// Purpose: Self-checking bench for the host sequencer against the converter model.
// Assumes: Skew limit shortened to 50 cycles; conversions last 20 to 51 cycles.
// Notes: Driver queues expected skew, read length and reset length; monitor compares.
`timescale 1ns/10ps
module acrs_host_bench;
  import acrs_pkg::*;
  localparam int MAXS = 50;
  logic mclk_i, rst_i, conv_req_i, reset_req_i, read_during_i, busy_pin_i;
  acrs_cnt_t stagger_i;
  logic ready_o, done_o, busy_o, start_group_a_o, start_group_b_o, conv_reset_o, cs_n_o;
  logic [31:0] dev_viol;
  real conv_ns;
  int miscompares, check_count, cyc_n, ta, skq, csl, rl, seed, stg;
  logic pa, pb, pr;
  int q[$];
  acrs_host #(.MAX_SKEW_CYC(MAXS)) dut (.mclk_i(mclk_i), .rst_i(rst_i),
    .conv_req_i(conv_req_i), .reset_req_i(reset_req_i), .read_during_i(read_during_i),
    .stagger_i(stagger_i), .ready_o(ready_o), .done_o(done_o), .busy_o(busy_o),
    .busy_pin_i(busy_pin_i), .start_group_a_o(start_group_a_o),
    .start_group_b_o(start_group_b_o), .conv_reset_o(conv_reset_o), .cs_n_o(cs_n_o));
  acrs_dev_model #(.SKEW_NS(MAXS * 50.0)) dev (.start_group_a_i(start_group_a_o),
    .start_group_b_i(start_group_b_o), .conv_reset_i(conv_reset_o), .cs_n_i(cs_n_o),
    .read_during_i(read_during_i), .conv_ns_i(conv_ns), .busy_o(busy_pin_i),
    .viol_o(dev_viol));
  // Clock
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %0d expected %0d", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wait_hi(ref logic s);
    do @(negedge mclk_i); while (s !== 1'b1);
    @(posedge mclk_i);
  endtask
  // Monitor measures skew, read length and reset pulse
  always @(negedge mclk_i) begin
    if (start_group_a_o === 1'b1 && pa !== 1'b1) ta = cyc_n;
    if (start_group_b_o === 1'b1 && pb !== 1'b1) skq = cyc_n - ta;
    if (cs_n_o === 1'b0) csl++;
    if (conv_reset_o === 1'b1 && rst_i === 1'b0) rl++;
    else if (conv_reset_o === 1'b0) begin
      if (pr === 1'b1 && q.size() > 0) check(rl, q.pop_front());
      rl = 0;
    end
    if (done_o === 1'b1) begin
      check(skq, q.pop_front());
      check(csl, q.pop_front());
      csl = 0;
      skq = -1;
    end
    pa = start_group_a_o;
    pb = start_group_b_o;
    pr = conv_reset_o;
    cyc_n++;
    if (cyc_n == 20000) begin
      miscompares++;
      final_report();
    end
  end
  // Main sequence
  initial begin
    seed = 68241;
    rst_i = 1'b1;
    conv_req_i = 1'b0;
    reset_req_i = 1'b0;
    read_during_i = 1'b0;
    stagger_i = '0;
    conv_ns = 1000.0;
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 14; i++) begin
      wait_hi(ready_o);
      if (i % 4 == 3) begin
        q.push_back(int'(RST_CYC));
        reset_req_i <= 1'b1;
        wait_hi(conv_reset_o);
        reset_req_i <= 1'b0;
        wait_hi(ready_o);
      end
      stg = (i == 0) ? 0 : (i == 1) ? MAXS + 9 : ($random(seed) & 63);
      q.push_back(stg > MAXS ? MAXS : stg);
      q.push_back(int'(READ_CYC));
      conv_ns <= 1000.0 + ($random(seed) & 31) * 50.0;
      read_during_i <= (i < 2) ? i[0] : ($random(seed) % 2 != 0);
      stagger_i <= acrs_cnt_t'(stg);
      conv_req_i <= 1'b1;
      wait_hi(start_group_a_o);
      conv_req_i <= 1'b0;
      wait_hi(done_o);
    end
    repeat (5) @(posedge mclk_i);
    check(dev_viol, 0);
    check(q.size(), 0);
    final_report();
  end
endmodule
